// File: common/mfsb_pkg.sv
package mfsb_pkg;

  // ==========================================================================
  // Channels and widths
  localparam int unsigned NUM_CH      = 5;
  localparam int unsigned CH_TEMP     = 0;
  localparam int unsigned VALUE_W     = 16;
  localparam int unsigned LIMIT_BYTES = 40;
  localparam int unsigned LIM_PER_CH  = 8;

  // Byte offsets of the four limits inside one channel's eight-byte group.
  localparam int unsigned LIM_ALARM_HI = 0;
  localparam int unsigned LIM_ALARM_LO = 2;
  localparam int unsigned LIM_WARN_HI  = 4;
  localparam int unsigned LIM_WARN_LO  = 6;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h00;
  localparam logic [7:0] ADDR_ALARM_PRI  = 8'h70;
  localparam logic [7:0] ADDR_ALARM_SEC  = 8'h71;
  localparam logic [7:0] ADDR_WARN_PRI   = 8'h74;
  localparam logic [7:0] ADDR_WARN_SEC   = 8'h75;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h76;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h77;
  localparam logic [7:0] ADDR_TABLE_SEL  = 8'h7f;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h88;
  localparam logic [7:0] ADDR_UPPER_BASE = 8'h80;
  localparam logic [1:0] TABLE_INT       = 2'h1;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned SUMMARY_BIT    = 0;
  localparam int unsigned ENABLE_TOP_BIT = 7;
  localparam logic [7:0]  INT_ENABLE_RST = 8'h80;
  localparam logic [1:0]  TABLE_SEL_RST  = 2'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mfsb_bus_req_t;

  typedef struct packed {
    logic               valid;
    logic [2:0]         channel;
    logic [VALUE_W-1:0] value;
  } mfsb_conv_t;

  typedef struct packed {
    logic [LIMIT_BYTES*8-1:0] limits;
    logic [NUM_CH-1:0]        alarm_hi;
    logic [NUM_CH-1:0]        alarm_lo;
    logic [NUM_CH-1:0]        warn_hi;
    logic [NUM_CH-1:0]        warn_lo;
    logic [7:0]               int_enable;
    logic [1:0]               table_sel;
    logic [NUM_CH-1:0]        irq_status;
    logic [NUM_CH-1:0]        irq_mask;
    logic                     summary;
    logic                     irq;
    logic [7:0]               rd_data;
  } mfsb_state_t;

endpackage

// File: hdl/mfsb_top.sv
`timescale 1ns/1ps
`default_nettype none

module mfsb_top (
  // Clock, reset and enable
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,

  // Register port
  input  wire mfsb_pkg::mfsb_bus_req_t bus_req,
  output logic [7:0]                 rd_data,

  // Conversion results
  input  wire mfsb_pkg::mfsb_conv_t  conv,

  // Status outputs
  output logic                       masked_interrupt_summary,
  output logic [1:0]                 table_select,
  output logic                       irq
);

  // ==========================================================================
  // State
  mfsb_pkg::mfsb_state_t state_reg;
  mfsb_pkg::mfsb_state_t state_next;

  // ==========================================================================
  // Per-channel limit compare
  logic [mfsb_pkg::NUM_CH-1:0] above_alarm;
  logic [mfsb_pkg::NUM_CH-1:0] below_alarm;
  logic [mfsb_pkg::NUM_CH-1:0] above_warn;
  logic [mfsb_pkg::NUM_CH-1:0] below_warn;
  logic [mfsb_pkg::NUM_CH-1:0] conv_hit;
  logic [mfsb_pkg::NUM_CH-1:0] chan_enable;

  genvar c;
  generate
    for (c = 0; c < mfsb_pkg::NUM_CH; c++) begin : g_chan
      localparam int unsigned BASE = c * mfsb_pkg::LIM_PER_CH;
      logic [mfsb_pkg::VALUE_W-1:0] lim_ah;
      logic [mfsb_pkg::VALUE_W-1:0] lim_al;
      logic [mfsb_pkg::VALUE_W-1:0] lim_wh;
      logic [mfsb_pkg::VALUE_W-1:0] lim_wl;

      // Limits are stored most significant byte first.
      assign lim_ah = {state_reg.limits[(BASE + mfsb_pkg::LIM_ALARM_HI)*8 +: 8],
                       state_reg.limits[(BASE + mfsb_pkg::LIM_ALARM_HI + 1)*8 +: 8]};
      assign lim_al = {state_reg.limits[(BASE + mfsb_pkg::LIM_ALARM_LO)*8 +: 8],
                       state_reg.limits[(BASE + mfsb_pkg::LIM_ALARM_LO + 1)*8 +: 8]};
      assign lim_wh = {state_reg.limits[(BASE + mfsb_pkg::LIM_WARN_HI)*8 +: 8],
                       state_reg.limits[(BASE + mfsb_pkg::LIM_WARN_HI + 1)*8 +: 8]};
      assign lim_wl = {state_reg.limits[(BASE + mfsb_pkg::LIM_WARN_LO)*8 +: 8],
                       state_reg.limits[(BASE + mfsb_pkg::LIM_WARN_LO + 1)*8 +: 8]};

      // Temperature is two's complement; the other channels are unsigned.
      if (c == mfsb_pkg::CH_TEMP) begin : g_signed
        assign above_alarm[c] = $signed(conv.value) > $signed(lim_ah);
        assign below_alarm[c] = $signed(conv.value) < $signed(lim_al);
        assign above_warn[c]  = $signed(conv.value) > $signed(lim_wh);
        assign below_warn[c]  = $signed(conv.value) < $signed(lim_wl);
      end else begin : g_unsigned
        assign above_alarm[c] = conv.value > lim_ah;
        assign below_alarm[c] = conv.value < lim_al;
        assign above_warn[c]  = conv.value > lim_wh;
        assign below_warn[c]  = conv.value < lim_wl;
      end

      assign conv_hit[c] = conv.valid && (conv.channel == 3'(c));
      // Enable bits run from bit 7 for temperature downward.
      assign chan_enable[c] = state_reg.int_enable[mfsb_pkg::ENABLE_TOP_BIT - c];
    end
  endgenerate

  // ==========================================================================
  // Flag byte packing
  function automatic logic [7:0] pack_flags(
    input logic [mfsb_pkg::NUM_CH-1:0] hi,
    input logic [mfsb_pkg::NUM_CH-1:0] lo,
    input bit                          secondary
  );
    logic [7:0] b;
    b = 8'h00;
    if (secondary) begin
      b[7] = hi[4];
      b[6] = lo[4];
    end else begin
      b = {hi[0], lo[0], hi[1], lo[1], hi[2], lo[2], hi[3], lo[3]};
    end
    return b;
  endfunction

  // ==========================================================================
  // Next state
  logic [mfsb_pkg::NUM_CH-1:0] new_alarm_hi;
  logic [mfsb_pkg::NUM_CH-1:0] new_alarm_lo;
  logic [mfsb_pkg::NUM_CH-1:0] new_warn_hi;
  logic [mfsb_pkg::NUM_CH-1:0] new_warn_lo;
  logic [mfsb_pkg::NUM_CH-1:0] chan_flagged;
  logic [mfsb_pkg::NUM_CH-1:0] chan_was;
  logic [mfsb_pkg::NUM_CH-1:0] irq_set;
  logic [mfsb_pkg::NUM_CH-1:0] irq_clr;
  logic [7:0]                  read_word;
  logic                        upper_int_table;
  logic                        in_limits;

  always_comb begin
    state_next = state_reg;

    // A flag is recomputed only when its own channel converts.
    new_alarm_hi = (state_reg.alarm_hi & ~conv_hit) | (above_alarm & conv_hit);
    new_alarm_lo = (state_reg.alarm_lo & ~conv_hit) | (below_alarm & conv_hit);
    new_warn_hi  = (state_reg.warn_hi & ~conv_hit) | (above_warn & conv_hit);
    new_warn_lo  = (state_reg.warn_lo & ~conv_hit) | (below_warn & conv_hit);
    state_next.alarm_hi = new_alarm_hi;
    state_next.alarm_lo = new_alarm_lo;
    state_next.warn_hi  = new_warn_hi;
    state_next.warn_lo  = new_warn_lo;

    // The summary bit sees only the channels whose enable bit is one.
    chan_flagged = new_alarm_hi | new_alarm_lo | new_warn_hi | new_warn_lo;
    state_next.summary = |(chan_flagged & chan_enable);

    // A channel raises its sticky event when it goes from no flag to some flag.
    chan_was = state_reg.alarm_hi | state_reg.alarm_lo | state_reg.warn_hi | state_reg.warn_lo;
    irq_set  = chan_flagged & ~chan_was;

    upper_int_table = state_reg.table_sel == mfsb_pkg::TABLE_INT;
    in_limits = bus_req.addr < (mfsb_pkg::ADDR_LIMIT_BASE + 8'(mfsb_pkg::LIMIT_BYTES));

    // Register writes; the flag bytes have no write path.
    irq_clr = '0;
    if (bus_req.wr) begin
      if (in_limits) begin
        state_next.limits[bus_req.addr * 8 +: 8] = bus_req.wdata;
      end
      case (bus_req.addr)
        mfsb_pkg::ADDR_TABLE_SEL: begin
          state_next.table_sel = bus_req.wdata[1:0];
        end
        mfsb_pkg::ADDR_IRQ_STATUS: begin
          irq_clr = bus_req.wdata[mfsb_pkg::NUM_CH-1:0];
        end
        mfsb_pkg::ADDR_IRQ_MASK: begin
          state_next.irq_mask = bus_req.wdata[mfsb_pkg::NUM_CH-1:0];
        end
        mfsb_pkg::ADDR_INT_ENABLE: begin
          if (upper_int_table) begin
            state_next.int_enable = bus_req.wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // A new event wins over a clear in the same cycle.
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;
    // The next mask is used so that a mask write acts on the interrupt at once.
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);

    // Reads answer in the next cycle only; unmapped bytes read zero.
    read_word = 8'h00;
    if (in_limits) begin
      read_word = state_reg.limits[bus_req.addr * 8 +: 8];
    end
    case (bus_req.addr)
      mfsb_pkg::ADDR_ALARM_PRI: begin
        read_word = pack_flags(state_reg.alarm_hi, state_reg.alarm_lo, 1'b0);
      end
      mfsb_pkg::ADDR_ALARM_SEC: begin
        read_word = pack_flags(state_reg.alarm_hi, state_reg.alarm_lo, 1'b1);
        read_word[mfsb_pkg::SUMMARY_BIT] = state_reg.summary;
      end
      mfsb_pkg::ADDR_WARN_PRI: begin
        read_word = pack_flags(state_reg.warn_hi, state_reg.warn_lo, 1'b0);
      end
      mfsb_pkg::ADDR_WARN_SEC: begin
        read_word = pack_flags(state_reg.warn_hi, state_reg.warn_lo, 1'b1);
      end
      mfsb_pkg::ADDR_IRQ_STATUS: begin
        read_word = {3'h0, state_reg.irq_status};
      end
      mfsb_pkg::ADDR_IRQ_MASK: begin
        read_word = {3'h0, state_reg.irq_mask};
      end
      mfsb_pkg::ADDR_TABLE_SEL: begin
        read_word = {6'h00, state_reg.table_sel};
      end
      mfsb_pkg::ADDR_INT_ENABLE: begin
        if (upper_int_table) begin
          read_word = state_reg.int_enable;
        end
      end
      default: begin
      end
    endcase
    state_next.rd_data = bus_req.rd ? read_word : 8'h00;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg            <= '0;
      state_reg.int_enable <= mfsb_pkg::INT_ENABLE_RST;
      state_reg.table_sel  <= mfsb_pkg::TABLE_SEL_RST;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign rd_data                  = state_reg.rd_data;
  assign masked_interrupt_summary = state_reg.summary;
  assign table_select             = state_reg.table_sel;
  assign irq                      = state_reg.irq;

endmodule // mfsb_top

`default_nettype wire

// File: verification/mfsb_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module mfsb_assertions (
  // Clock, reset and enable
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    ce,
  // Register port
  input wire mfsb_pkg::mfsb_bus_req_t bus_req,
  input wire logic [7:0]              rd_data,
  // Conversion results
  input wire mfsb_pkg::mfsb_conv_t    conv,
  // Status outputs
  input wire logic                    masked_interrupt_summary,
  input wire logic [1:0]              table_select,
  input wire logic                    irq
);
  logic [7:0] enable_reg;

  // ==========================================================================
  // Shadow of the enable byte, which is only reachable in table one.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= mfsb_pkg::INT_ENABLE_RST;
    end else if (ce && bus_req.wr && bus_req.addr == 8'h88 && table_select == 2'h1) begin
      enable_reg <= bus_req.wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Properties
  property p_tsel_write;
    ce && bus_req.wr && bus_req.addr == 8'h7f |=> table_select == $past(bus_req.wdata[1:0]);
  endproperty
  a_tsel_write: assert property (p_tsel_write) else $error("table select not written");
  property p_tsel_hold;
    !(ce && bus_req.wr && bus_req.addr == 8'h7f) |=> $stable(table_select);
  endproperty
  a_tsel_hold: assert property (p_tsel_hold) else $error("table select changed alone");
  property p_tsel_read;
    ce && bus_req.rd && bus_req.addr == 8'h7f |=> rd_data == {6'h00, $past(table_select)};
  endproperty
  a_tsel_read: assert property (p_tsel_read) else $error("table select readback wrong");
  property p_rd_idle;
    ce && !bus_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_alarm_sec;
    ce && bus_req.rd && bus_req.addr == 8'h71 |=>
      rd_data[5:1] == 5'h00 && rd_data[0] == $past(masked_interrupt_summary);
  endproperty
  a_alarm_sec: assert property (p_alarm_sec) else $error("second alarm byte wrong");
  property p_warn_sec;
    ce && bus_req.rd && bus_req.addr == 8'h75 |=> rd_data[5:0] == 6'h00;
  endproperty
  a_warn_sec: assert property (p_warn_sec) else $error("unused warning bits set");
  property p_mute;
    ce && enable_reg == 8'h00 |=> !masked_interrupt_summary;
  endproperty
  a_mute: assert property (p_mute) else $error("summary set with no enables");
  property p_enable_hidden;
    ce && bus_req.rd && bus_req.addr == 8'h88 && table_select != 2'h1 |=> rd_data == 8'h00;
  endproperty
  a_enable_hidden: assert property (p_enable_hidden) else $error("enable byte seen");
endmodule // mfsb_assertions

bind mfsb_top mfsb_assertions u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
  .rd_data(rd_data), .conv(conv), .masked_interrupt_summary(masked_interrupt_summary),
  .table_select(table_select), .irq(irq));

`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    ce = 1'b1;
  mfsb_pkg::mfsb_bus_req_t bus_req = '0;
  mfsb_pkg::mfsb_conv_t    conv = '0;
  logic [7:0]              rd_data;
  logic                    summary;
  logic [1:0]              table_select;
  logic                    irq;
  logic [9:0]              fv;
  logic [7:0]              lim [4] = '{8'h10, 8'h01, 8'h08, 8'h02};
  int                      n_mismatch = 0;
  int                      num_checks = 0;

  mfsb_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
    .conv(conv), .masked_interrupt_summary(summary), .table_select(table_select), .irq(irq));

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask
  task automatic cv(input logic [2:0] ch, input logic [15:0] v);
    @(posedge clk);
    conv <= '{valid: 1'b1, channel: ch, value: v};
    @(posedge clk);
    conv.valid <= 1'b0;
  endtask
  task automatic flags(input logic [9:0] al, input logic [9:0] wn, input logic s);
    rd(8'h70, al[9:2]);
    rd(8'h71, {al[1:0], 5'h00, s});
    rd(8'h74, wn[9:2]);
    rd(8'h75, {wn[1:0], 6'h00});
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    flags(10'h000, 10'h000, 1'b0);
    rd(8'h7f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h7f, 8'hfc | 8'(i));
      rd(8'h7f, 8'(i));
      check({6'h00, table_select}, 8'(i));
    end
    wr(8'h7f, 8'h01);
    rd(8'h88, 8'h80);
    // Each channel is driven above, below and back inside its limits.
    for (int c = 0; c < 5; c++) begin
      for (int k = 0; k < 4; k++) wr(8'(8 * c + 2 * k), lim[k]);
      fv = 10'h200 >> (2 * c);
      cv(3'(c), 16'h2000);
      flags(fv, fv, c == 0);
      cv(3'(c), 16'h0050);
      flags(fv >> 1, fv >> 1, c == 0);
      cv(3'(c), 16'h0400);
      flags(10'h000, 10'h000, 1'b0);
    end
    rd(8'h76, 8'h1f);
    check({7'h00, irq}, 8'h00);
    wr(8'h76, 8'h1f);
    rd(8'h76, 8'h00);
    // Supply alone enabled, then every enable cleared.
    wr(8'h77, 8'h02);
    wr(8'h88, 8'h40);
    cv(3'h1, 16'h2000);
    rd(8'h71, 8'h01);
    check({7'h00, summary}, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(8'h77, 8'h00);
    rd(8'h77, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(8'h77, 8'h02);
    rd(8'h77, 8'h02);
    check({7'h00, irq}, 8'h01);
    wr(8'h88, 8'h00);
    rd(8'h71, 8'h00);
    check({7'h00, summary}, 8'h00);
    wr(8'h76, 8'h02);
    rd(8'h76, 8'h00);
    check({7'h00, irq}, 8'h00);
    // Writes to read-only and hidden places change nothing; an unmapped byte reads zero.
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h20);
    wr(8'h7f, 8'h00);
    wr(8'h88, 8'hff);
    rd(8'h88, 8'h00);
    rd(8'h50, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    cv(3'h1, 16'h0400);
    ce <= 1'b1;
    rd(8'h70, 8'h20);
    // A conversion tagged with an unused channel number changes no flag.
    cv(3'h5, 16'h0400);
    rd(8'h70, 8'h20);
    // A negative temperature must compare as signed and raise the low flags.
    cv(3'h0, 16'hff00);
    rd(8'h70, 8'h60);
    rd(8'h74, 8'h60);
    final_report();
  end
endmodule // tb

`default_nettype wire
